// ===== hw/afx_ctrl.sv
// Host controller that drives one or more asynchronous nine-bit buffers through their pins.
// Functional notes
// [R1] Single mode ties chain inputs low.
// [R2] Depth cascade: exactly one first-load select low.
// [R3] Depth cascade: all other first-load selects high.
// [R4] Chain outputs feed next chain inputs, ring.
// [R5] Depth composite flags are OR of active-low flags.
// [R6] Depth cascade offers no rewind, no half flag.
// [R7] Width mode shares controls, flags from one device.
// [R8] Paired buffers may use either expansion.
// [R9] Read flow-through drives word after write edge.
// [R10] Flow-through word held until read strobe rises.
// [R11] Write flow-through: full re-asserts, store on rise.
// [R12] Write strobe toggles only while not full.
// [R13] Single/width reset zeroes pointers, sets flags.
// [R14] Rewind returns read pointer, keeps write pointer.
// [R15] Pointers advance only while their flag high.
// [R16] Depth reset zeroes pointers regardless of first-load.
// [R17] Chain output pulses at last location.
// [R18] Full flag low when write trails read.
// [R19] Empty flag low when pointers equal.
// [R20] Half flag low past half, released on read.
// [R21] Only token-holding devices accept writes or reads.
// [R22] Pointers wrap; occupancy is modular difference.
//
// The plain strobed port and the register offsets were left to the implementer.
`include "afx_cfg.svh"
module afx_ctrl #(
   parameter int NDEV = 2,
   parameter int DW = 9,
   parameter logic [7:0] STROBE_CYC = 8'(`AFX_STROBE_CYC),
   parameter logic [7:0] ACCESS_CYC = 8'(`AFX_ACCESS_CYC),
   parameter logic [7:0] INIT_CYC = 8'(`AFX_INIT_CYC),
   parameter logic [7:0] RECOVER_CYC = 8'(`AFX_RECOVER_CYC)
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic init_n_o,
   output logic wr_n_o,
   output logic rd_n_o,
   output logic [NDEV-1:0] chain_in_n_o,
   output logic [NDEV-1:0] rewind_first_load_n_o,
   input wire logic [NDEV-1:0] chain_out_n_i,
   input wire logic [NDEV-1:0] empty_flag_n_i,
   input wire logic [NDEV-1:0] full_flag_n_i,
   output logic [DW*NDEV-1:0] din_o,
   input wire logic [DW*NDEV-1:0] dout_i
);
   import afx_pkg::*;
   localparam logic [NDEV-1:0] FIRST_MASK = NDEV'(1);
   afx_strobe_if sif();
   afx_mode_t mode_r, mode_nxt;
   afx_state_t state_r, state_nxt;
   logic [DW*NDEV-1:0] wword_r, wword_nxt;
   logic [DW*NDEV-1:0] rword_r, rword_nxt;
   logic rvalid_r, rvalid_nxt;
   logic refused_r, refused_nxt;
   logic overrun_r, overrun_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic empty_c, full_c, half_c, depth_c;
   logic cmd_wr, wd_wr, st_wr, init_req, taken;
   logic [31:0] status_c;
   // ****************************************************************
   // Composite flags and chain routing
   // ****************************************************************
   assign depth_c = (mode_r == AFX_MODE_DEPTH);
   // In depth mode a composite flag is low only once every device reports it low.
   assign empty_c = depth_c ? (|empty_flag_n_i) : empty_flag_n_i[0]; // [R5] [R7]
   assign full_c = depth_c ? (|full_flag_n_i) : full_flag_n_i[0]; // [R5] [R7]
   // The half flag shares its pin with the chain output, so it means nothing in depth mode.
   assign half_c = depth_c ? 1'b1 : chain_out_n_i[0]; // [R6] [R7]
   genvar gi;
   generate
      for (gi = 0; gi < NDEV; gi++) begin : g_dev
         assign chain_in_n_o[gi] = depth_c ? chain_out_n_i[(gi + NDEV - 1) % NDEV] : 1'b0; // [R1] [R4]
         assign rewind_first_load_n_o[gi] = depth_c ? (gi != 0) : // [R2] [R3]
            ((state_r == AFX_ST_REWIND) ? sif.strobe_n : 1'b1); // [R14]
         ring_link_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R4]
            depth_c |-> (chain_in_n_o[gi] == chain_out_n_i[(gi + NDEV - 1) % NDEV]))
            else $error("Chain input not fed from previous device.");
      end
   endgenerate
   // ****************************************************************
   // Strobe routing
   // ****************************************************************
   // One pulser serves every strobe, so write, read, reset and rewind can never overlap.
   assign wr_n_o = (state_r == AFX_ST_WRITE) ? sif.strobe_n : 1'b1; // [R7]
   assign rd_n_o = (state_r == AFX_ST_READ) ? sif.strobe_n : 1'b1; // [R7]
   assign init_n_o = (state_r == AFX_ST_INIT) ? sif.strobe_n : 1'b1; // [R13] [R16]
   assign din_o = wword_r;
   afx_strobe u_strobe (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .pl(sif.pulser)
   );
   // ****************************************************************
   // Sequencer and registers
   // ****************************************************************
   assign cmd_wr = wr_i && (addr_i == `AFX_OFS_CMD);
   assign wd_wr = wr_i && (addr_i == `AFX_OFS_WDATA);
   assign st_wr = wr_i && (addr_i == `AFX_OFS_STATUS);
   assign init_req = cmd_wr && wdata_i[`AFX_CMD_INIT];
   always_comb begin
      status_c = 32'h0000_0000;
      status_c[`AFX_ST_BUSY] = (state_r != AFX_ST_IDLE);
      status_c[`AFX_ST_EMPTY_N] = empty_c;
      status_c[`AFX_ST_FULL_N] = full_c;
      status_c[`AFX_ST_HALF_N] = half_c;
      status_c[`AFX_ST_RVALID] = rvalid_r;
      status_c[`AFX_ST_REFUSED] = refused_r;
      status_c[`AFX_ST_OVERRUN] = overrun_r;
   end
   always_comb begin
      state_nxt = state_r;
      mode_nxt = mode_r;
      wword_nxt = wword_r;
      rword_nxt = rword_r;
      rdata_nxt = 32'h0000_0000;
      taken = 1'b0;
      sif.start = 1'b0;
      sif.len_low = STROBE_CYC;
      sif.len_rec = RECOVER_CYC;
      rvalid_nxt = rvalid_r;
      refused_nxt = refused_r;
      overrun_nxt = overrun_r;
      if (wr_i && (addr_i == `AFX_OFS_CTRL)) begin
         case (wdata_i[`AFX_CTRL_MODE_MSB:`AFX_CTRL_MODE_LSB])
            2'h1: mode_nxt = AFX_MODE_WIDTH;
            2'h2: mode_nxt = AFX_MODE_DEPTH;
            default: mode_nxt = AFX_MODE_SINGLE;
         endcase
      end
      // A pending wait may be broken off by a device reset, which brings the flags back.
      if (init_req && (state_r == AFX_ST_IDLE || state_r == AFX_ST_WAIT_WR ||
          state_r == AFX_ST_WAIT_RD)) begin
         taken = 1'b1;
         sif.start = 1'b1;
         sif.len_low = INIT_CYC;
         state_nxt = AFX_ST_INIT;
      end else begin
         case (state_r)
            AFX_ST_IDLE: begin
               if (cmd_wr && wdata_i[`AFX_CMD_REWIND]) begin
                  taken = 1'b1;
                  if (depth_c) begin
                     refused_nxt = 1'b1; // [R6]
                  end else begin
                     sif.start = 1'b1;
                     state_nxt = AFX_ST_REWIND; // [R14]
                  end
               end else if (cmd_wr && wdata_i[`AFX_CMD_READ]) begin
                  taken = 1'b1;
                  state_nxt = AFX_ST_WAIT_RD;
               end else if (wd_wr) begin
                  taken = 1'b1;
                  wword_nxt = wdata_i[DW*NDEV-1:0];
                  if (depth_c) begin
                     wword_nxt = {NDEV{wdata_i[DW-1:0]}};
                  end
                  state_nxt = AFX_ST_WAIT_WR;
               end
            end
            AFX_ST_WAIT_WR: begin
               if (full_c) begin
                  sif.start = 1'b1; // [R12] [R11]
                  state_nxt = AFX_ST_WRITE;
               end
            end
            AFX_ST_WAIT_RD: begin
               if (empty_c) begin
                  sif.start = 1'b1; // [R15] [R9]
                  sif.len_low = (ACCESS_CYC > STROBE_CYC) ? ACCESS_CYC : STROBE_CYC;
                  state_nxt = AFX_ST_READ;
               end
            end
            AFX_ST_WRITE, AFX_ST_READ, AFX_ST_INIT, AFX_ST_REWIND: begin
               if (sif.done) begin
                  state_nxt = AFX_ST_IDLE;
               end
            end
            default: begin
               state_nxt = AFX_ST_IDLE;
            end
         endcase
      end
      // The word is taken in the last low cycle, after the access delay and before the rise.
      if (rd_i && (addr_i == `AFX_OFS_RDATA)) begin
         rvalid_nxt = 1'b0;
      end
      if ((state_r == AFX_ST_READ) && sif.sample) begin
         rword_nxt = dout_i; // [R10]
         if (depth_c) begin
            rword_nxt = '0;
            rword_nxt[DW-1:0] = dout_i[DW-1:0];
         end
         rvalid_nxt = 1'b1;
      end
      if (st_wr && wdata_i[`AFX_ST_REFUSED]) begin
         refused_nxt = 1'b0;
      end
      if (st_wr && wdata_i[`AFX_ST_OVERRUN]) begin
         overrun_nxt = 1'b0;
      end
      if ((cmd_wr || wd_wr) && !taken) begin
         overrun_nxt = 1'b1;
      end
      if (rd_i) begin
         case (addr_i)
            `AFX_OFS_CTRL: rdata_nxt = {30'h0000_0000, mode_r};
            `AFX_OFS_WDATA: rdata_nxt = 32'(wword_r);
            `AFX_OFS_RDATA: rdata_nxt = 32'(rword_r);
            `AFX_OFS_STATUS: rdata_nxt = status_c;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= AFX_ST_IDLE;
         mode_r <= afx_mode_t'(`AFX_CTRL_RESET);
         wword_r <= '0;
         rword_r <= '0;
         rvalid_r <= 1'b0;
         refused_r <= 1'b0;
         overrun_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         wword_r <= wword_nxt;
         rword_r <= rword_nxt;
         rvalid_r <= rvalid_nxt;
         refused_r <= refused_nxt;
         overrun_r <= overrun_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign rdata_o = rdata_r;
   // ****************************************************************
   // Checks
   // ****************************************************************
   single_chain_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R1]
      !depth_c |-> (chain_in_n_o == '0))
      else $error("Chain input not grounded outside depth mode.");
   first_sel_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R2]
      depth_c |-> !rewind_first_load_n_o[0])
      else $error("First device not selected in depth mode.");
   other_sel_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R3]
      depth_c |-> ((rewind_first_load_n_o | FIRST_MASK) == {NDEV{1'b1}}))
      else $error("A later device has first-load selected.");
   write_gate_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R12]
      $fell(wr_n_o) |-> $past(full_c))
      else $error("Write strobe fell while full.");
   depth_wr_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R5]
      ($fell(wr_n_o) && depth_c) |-> $past(|full_flag_n_i))
      else $error("Depth write with every device full.");
   depth_rd_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R5]
      ($fell(rd_n_o) && depth_c) |-> $past(|empty_flag_n_i))
      else $error("Depth read with every device empty.");
   width_flags_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R7]
      ($fell(rd_n_o) && !depth_c) |-> $past(empty_flag_n_i[0]))
      else $error("Read started while first device empty.");
   strobe_excl_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R8]
      !(!wr_n_o && !rd_n_o) && (init_n_o || (wr_n_o && rd_n_o)))
      else $error("Strobes overlap.");
   rewind_refuse_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R6]
      (depth_c && cmd_wr && wdata_i[`AFX_CMD_REWIND] && !init_req &&
       state_r == AFX_ST_IDLE) |=> (refused_r && state_r == AFX_ST_IDLE))
      else $error("Rewind not refused in depth mode.");
   read_capture_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R10]
      ((state_r == AFX_ST_READ) && sif.sample) |=> (rvalid_r && rd_n_o))
      else $error("Read word not captured at strobe rise.");
   // ****************************************************************
   // Link checks
   // ****************************************************************
   // The device latches the word on the rising strobe, so it must not move while low.
   wr_data_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R7] [R11]
      !wr_n_o |-> $stable(din_o))
      else $error("Write word changed under a low strobe.");
   // Composite empty counts in depth mode, the first device's flag otherwise.
   rd_gate_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R5] [R7]
      $fell(rd_n_o) |-> $past(empty_c))
      else $error("Read strobe fell while empty.");
   rd_sample_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R10]
      ((state_r == AFX_ST_READ) && sif.sample) |-> !rd_n_o)
      else $error("Read word sampled after the strobe rose.");
   // Init may cut a wait short, so its pulse must follow the very next edge.
   init_first_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R13] [R16]
      (init_req && (state_r == AFX_ST_IDLE || state_r == AFX_ST_WAIT_WR ||
       state_r == AFX_ST_WAIT_RD)) |=> !init_n_o)
      else $error("Accepted device reset gave no low pulse.");
   rewind_pins_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R7] [R14]
      (!depth_c && !rewind_first_load_n_o[0]) |->
      ((rewind_first_load_n_o == '0) && wr_n_o && rd_n_o && init_n_o))
      else $error("Rewind pulse not on every device alone.");
   depth_rewind_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R6]
      depth_c |-> (state_r != AFX_ST_REWIND))
      else $error("Rewind pulse issued in depth mode.");
   op_end_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R12]
      ((state_r == AFX_ST_WRITE) && sif.done) |=> (wr_n_o && state_r == AFX_ST_IDLE))
      else $error("Write did not end after its recovery.");
endmodule // afx_ctrl

// ===== hw/afx_cfg.svh
// Register map, field positions, reset values and timing counts of the buffer controller.
`ifndef AFX_CFG_SVH
`define AFX_CFG_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define AFX_OFS_CTRL 8'h00
`define AFX_OFS_CMD 8'h04
`define AFX_OFS_WDATA 8'h08
`define AFX_OFS_RDATA 8'h0C
`define AFX_OFS_STATUS 8'h10
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define AFX_CTRL_MODE_LSB 0
`define AFX_CTRL_MODE_MSB 1
`define AFX_CTRL_RESET 2'h0
`define AFX_CMD_INIT 0
`define AFX_CMD_REWIND 1
`define AFX_CMD_READ 2
`define AFX_ST_BUSY 0
`define AFX_ST_EMPTY_N 1
`define AFX_ST_FULL_N 2
`define AFX_ST_HALF_N 3
`define AFX_ST_RVALID 4
`define AFX_ST_REFUSED 5
`define AFX_ST_OVERRUN 6
// ****************************************************************
// Timing in ns and derived cycle counts
// ****************************************************************
`define AFX_CLK_NS 50
`define AFX_T_STROBE_NS 35
`define AFX_T_ACCESS_NS 25
`define AFX_T_INIT_NS 35
`define AFX_T_RECOVER_NS 35
`define AFX_STROBE_CYC ((`AFX_T_STROBE_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS)
`define AFX_ACCESS_CYC ((`AFX_T_ACCESS_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS)
`define AFX_INIT_CYC ((`AFX_T_INIT_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS)
`define AFX_RECOVER_CYC ((`AFX_T_RECOVER_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS)
`endif

// ===== hw/afx_pkg.sv
// Types shared by the buffer controller modules.
package afx_pkg;
   typedef enum logic [1:0] {
      AFX_MODE_SINGLE,
      AFX_MODE_WIDTH,
      AFX_MODE_DEPTH
   } afx_mode_t;
   typedef enum logic [2:0] {
      AFX_ST_IDLE,
      AFX_ST_WAIT_WR,
      AFX_ST_WRITE,
      AFX_ST_WAIT_RD,
      AFX_ST_READ,
      AFX_ST_INIT,
      AFX_ST_REWIND
   } afx_state_t;
   typedef enum logic [1:0] {
      AFX_PL_IDLE,
      AFX_PL_LOW,
      AFX_PL_REC
   } afx_pulse_t;
endpackage

// ===== hw/afx_strobe_if.sv
// Link between the controller sequencer and its strobe pulser.
interface afx_strobe_if;
   logic start;
   logic [7:0] len_low;
   logic [7:0] len_rec;
   logic strobe_n;
   logic sample;
   logic done;
   modport pulser(input start, input len_low, input len_rec,
                  output strobe_n, output sample, output done);
   modport seq(output start, output len_low, output len_rec,
               input strobe_n, input sample, input done);
endinterface

// ===== hw/afx_strobe.sv
// Active-low strobe pulser with a low phase and a recovery phase.
module afx_strobe (
   input wire logic clock_i,
   input wire logic reset_i,
   afx_strobe_if.pulser pl
);
   import afx_pkg::*;
   afx_pulse_t state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic strobe_n_r, strobe_n_nxt;
   // ****************************************************************
   // Pulse sequence
   // ****************************************************************
   // Lengths below one cycle are never requested, so the count cannot wrap.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         AFX_PL_IDLE: begin
            if (pl.start) begin
               state_nxt = AFX_PL_LOW;
               cnt_nxt = pl.len_low - 8'h01;
            end
         end
         AFX_PL_LOW: begin
            if (cnt_r == 8'h00) begin
               state_nxt = AFX_PL_REC;
               cnt_nxt = pl.len_rec - 8'h01;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         AFX_PL_REC: begin
            if (cnt_r == 8'h00) begin
               state_nxt = AFX_PL_IDLE;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         default: begin
            state_nxt = AFX_PL_IDLE;
         end
      endcase
      strobe_n_nxt = (state_nxt != AFX_PL_LOW);
   end
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= AFX_PL_IDLE;
         cnt_r <= 8'h00;
         strobe_n_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         strobe_n_r <= strobe_n_nxt;
      end
   end
   assign pl.strobe_n = strobe_n_r;
   assign pl.sample = (state_r == AFX_PL_LOW) && (cnt_r == 8'h00);
   assign pl.done = (state_r == AFX_PL_REC) && (cnt_r == 8'h00);
   // ****************************************************************
   // Checks
   // ****************************************************************
   sample_low_a: assert property (@(posedge clock_i) disable iff (reset_i)
      pl.sample |=> pl.strobe_n)
      else $error("Strobe still low after its sample cycle.");
endmodule // afx_strobe

// ===== sim/afx_dev_model.sv
// Behavioural model of the nine-bit buffers that the controller drives.
module afx_dev_model #(
   parameter int N = 2,
   parameter int D = 4
) (
   input wire logic init_n_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   input wire logic [N-1:0] chain_in_n_i,
   input wire logic [N-1:0] rfl_n_i,
   output logic [N-1:0] chain_out_n_o,
   output logic [N-1:0] empty_flag_n_o,
   output logic [N-1:0] full_flag_n_o,
   input wire logic [9*N-1:0] din_i,
   output logic [9*N-1:0] dout_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // A small depth stands in for the real capacity so full is reached quickly.
   logic [8:0] mem [N][D];
   int wp [N];
   int rp [N];
   int cnt [N];
   int wt = 0;
   int rt = 0;
   logic dep = 1'b0;
   logic [N-1:0] xo_n = '1;
   initial dout_o = '0;
   always @(negedge init_n_i) begin
      for (int i = 0; i < N; i++) begin
         wp[i] = 0;
         rp[i] = 0;
         cnt[i] = 0;
         if (rfl_n_i[i] === 1'b0) begin
            wt = i;
            rt = i;
         end
      end
   end
   // The mode is taken on the rising reset edge, once the cleared flags have reached the chain.
   always @(posedge init_n_i) begin
      dep = chain_in_n_i[0];
   end
   always @(posedge wr_n_i) begin
      int t;
      t = wt;
      for (int i = 0; i < N; i++) begin
         if ((!dep || i == t) && cnt[i] < D) begin
            mem[i][wp[i]] = dep ? din_i[8:0] : din_i[9*i +: 9];
            wp[i] = (wp[i] + 1) % D;
            cnt[i]++;
            // A read strobe already low on an empty device shows the new word at once.
            if (rd_n_i === 1'b0 && cnt[i] == 1 && (!dep || i == rt)) begin
               dout_o[(dep ? 0 : 9*i) +: 9] = mem[i][rp[i]];
            end
            if (dep && wp[i] == 0) begin
               wt = (i + 1) % N;
               xo_n[i] = 1'b0;
               xo_n[i] <= #10 1'b1;
            end
         end
      end
   end
   always @(negedge rd_n_i) begin
      for (int i = 0; i < N; i++) begin
         if ((!dep || i == rt) && cnt[i] > 0) begin
            dout_o[(dep ? 0 : 9*i) +: 9] = mem[i][rp[i]];
         end
      end
   end
   always @(posedge rd_n_i) begin
      int t;
      t = rt;
      for (int i = 0; i < N; i++) begin
         if ((!dep || i == t) && cnt[i] > 0) begin
            rp[i] = (rp[i] + 1) % D;
            cnt[i]--;
            if (dep && rp[i] == 0) begin
               rt = (i + 1) % N;
            end
         end
      end
      // A released bus shows the inverse of its last word, so a late sample cannot pass.
      dout_o = ~dout_o;
   end
   always @(negedge rfl_n_i[0]) begin
      for (int i = 0; i < N; i++) begin
         if (!dep) begin
            rp[i] = 0;
            cnt[i] = wp[i];
         end
      end
   end
   for (genvar g = 0; g < N; g++) begin : g_flag
      assign empty_flag_n_o[g] = (cnt[g] != 0);
      assign full_flag_n_o[g] = (cnt[g] != D);
      assign chain_out_n_o[g] = dep ? xo_n[g] : (cnt[g] <= D / 2);
   end
endmodule // afx_dev_model

// ===== sim/test_afx_ctrl.sv
// Self-checking bench of the buffer controller against a queue model of the buffers.
`include "afx_cfg.svh"
module test_afx_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   import afx_pkg::*;
   localparam int D = 4;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] rdata_o;
   logic init_n, wr_n, rd_n, dep;
   logic [1:0] cin_n, rfl_n, cout_n, ef_n, ff_n;
   logic [17:0] din, dout;
   int n_fail = 0;
   int n_compared = 0;
   int seed = 31929;
   int cap;
   logic [31:0] v, wm;
   logic [31:0] q [$];
   logic [31:0] hist [$];
   always #25 clock_i = ~clock_i;
   afx_ctrl i_dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .init_n_o(init_n), .wr_n_o(wr_n),
      .rd_n_o(rd_n), .chain_in_n_o(cin_n), .rewind_first_load_n_o(rfl_n),
      .chain_out_n_i(cout_n), .empty_flag_n_i(ef_n), .full_flag_n_i(ff_n), .din_o(din),
      .dout_i(dout));
   afx_dev_model #(.N(2), .D(D)) i_dev (.init_n_i(init_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
      .chain_in_n_i(cin_n), .rfl_n_i(rfl_n), .chain_out_n_o(cout_n), .empty_flag_n_o(ef_n),
      .full_flag_n_o(ff_n), .din_i(din), .dout_o(dout));
   // ****************************
   // Bus tasks and checks
   // ****************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic br(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic idle();
      for (int k = 0; k < 40; k++) begin
         br(`AFX_OFS_STATUS, v);
         if (v[0] === 1'b0) return;
      end
      n_fail++;
      print_verdict();
   endtask
   task automatic st();
      br(`AFX_OFS_STATUS, v);
      chk(32'(v[3:0]), 32'({dep || q.size() <= D / 2, q.size() != cap, q.size() != 0,
         1'b0}));
   endtask
   task automatic put();
      logic [31:0] w;
      w = $random(seed) & wm;
      bw(`AFX_OFS_WDATA, w);
      idle();
      q.push_back(w);
      hist.push_back(w);
      st();
   endtask
   task automatic get();
      bw(`AFX_OFS_CMD, 32'h4);
      idle();
      br(`AFX_OFS_RDATA, v);
      chk(v, q.pop_front());
      st();
   endtask
   task automatic start(input afx_mode_t m);
      bw(`AFX_OFS_CTRL, 32'(m));
      bw(`AFX_OFS_CMD, 32'h1);
      idle();
      dep = (m == AFX_MODE_DEPTH);
      cap = dep ? 2 * D : D;
      wm = dep ? 32'h1FF : 32'h3FFFF;
      q = {};
      hist = {};
      st();
   endtask
   // ****************************
   // Main sequence
   // ****************************
   initial begin
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      br(`AFX_OFS_CTRL, v);
      chk(v, 32'h0);
      br(8'h20, v);
      chk(v, 32'h0);
      for (int j = 0; j < 2; j++) begin
         start(j ? AFX_MODE_SINGLE : AFX_MODE_WIDTH);
         chk(32'(cin_n), 32'h0);
         repeat (D) put();
         // The write offered to a full buffer must wait; only init may break the wait.
         bw(`AFX_OFS_WDATA, 32'h5);
         br(`AFX_OFS_STATUS, v);
         chk(32'(v[0]), 32'h1);
         bw(`AFX_OFS_CMD, 32'h1);
         idle();
         q = {};
         hist = {};
         st();
         repeat (3) put();
         repeat (2) get();
         bw(`AFX_OFS_CMD, 32'h2);
         idle();
         q = hist;
         st();
         repeat (3) get();
         repeat (2 * D) begin
            put();
            get();
         end
      end
      start(AFX_MODE_DEPTH);
      chk(32'(rfl_n), 32'h2);
      chk(32'(cin_n), 32'({cout_n[0], cout_n[1]}));
      repeat (2 * D) put();
      repeat (2 * D) get();
      bw(`AFX_OFS_CMD, 32'h2);
      idle();
      br(`AFX_OFS_STATUS, v);
      chk(32'(v[5]), 32'h1);
      bw(`AFX_OFS_STATUS, 32'h20);
      br(`AFX_OFS_STATUS, v);
      chk(32'(v[5]), 32'h0);
      print_verdict();
   end
endmodule // test_afx_ctrl
